//--- logic/dcms_pkg.sv
package dcms_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_FREQ_HZ          = 200_000_000;
    // Sample periods in microseconds per speed grade
    localparam int unsigned SAMPLE_PERIOD_FAST_US = 4630;
    localparam int unsigned SAMPLE_PERIOD_MED_US  = 50000;
    localparam int unsigned SAMPLE_PERIOD_SLOW_US = 100000;
    localparam longint unsigned SAMPLE_PERIOD_FAST_CYC =
        (longint'(SAMPLE_PERIOD_FAST_US) * CLK_FREQ_HZ) / 1_000_000;
    localparam longint unsigned SAMPLE_PERIOD_MED_CYC =
        (longint'(SAMPLE_PERIOD_MED_US) * CLK_FREQ_HZ) / 1_000_000;
    localparam longint unsigned SAMPLE_PERIOD_SLOW_CYC =
        (longint'(SAMPLE_PERIOD_SLOW_US) * CLK_FREQ_HZ) / 1_000_000;
    // Power-on settle time, microseconds, and active window in cycles
    localparam int unsigned POWER_ON_SETTLE_TIME_US = 140;
    localparam longint unsigned POWER_ON_SETTLE_CYC =
        (longint'(POWER_ON_SETTLE_TIME_US) * CLK_FREQ_HZ) / 1_000_000;
    localparam int unsigned CNT_W = 32;

    // ****************************************************************
    // Field sample format: signed, units of 0.1 mT
    // ****************************************************************
    localparam int unsigned FIELD_W = 16;
    localparam logic [FIELD_W-1:0] OPERATE_THRESHOLD_DEF = 16'h001E; // 3.0 mT
    localparam logic [FIELD_W-1:0] RELEASE_THRESHOLD_DEF = 16'h0016; // 2.2 mT

    typedef struct packed {
        logic               valid;
        logic [FIELD_W-1:0] bz;
    } dcms_sample_s;

    typedef enum logic [1:0] {
        DCMS_SETTLE  = 2'b00,
        DCMS_MEASURE = 2'b01,
        DCMS_SLEEP   = 2'b11
    } dcms_state_e;

endpackage

//--- logic/dcms_switch.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Output low on field, high otherwise
// - Either polarity detected the same way
// - Perpendicular component only, bottom-to-top positive
// - Wake, sample, update, sleep, oscillator paced
// - First sample valid within power-on settle time
// - Output latched through each sleep interval
// - New sample each period, change only on difference
// - Single fixed operating mode, no selection
// - Sample period fixed per speed grade
// - Assert low when magnitude reaches operate threshold
// - Release high when magnitude below release threshold
module dcms_switch #(
    parameter longint unsigned SAMPLE_PERIOD_CYC = dcms_pkg::SAMPLE_PERIOD_MED_CYC,
    parameter longint unsigned SETTLE_CYC        = dcms_pkg::POWER_ON_SETTLE_CYC,
    parameter logic [15:0]     OPERATE_THRESHOLD = dcms_pkg::OPERATE_THRESHOLD_DEF,
    parameter logic [15:0]     RELEASE_THRESHOLD = dcms_pkg::RELEASE_THRESHOLD_DEF
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire dcms_pkg::dcms_sample_s sample,
    output logic                      sample_req,
    output logic                      switch_out,
    output logic                      awake
);

    // ****************************************************************
    // Magnitude of the perpendicular field
    // ****************************************************************
    function automatic logic [15:0] dcms_abs(input logic [15:0] v);
        return v[15] ? 16'(~v + 16'h0001) : v;
    endfunction

    dcms_pkg::dcms_state_e state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic        out_q, out_d;
    logic        first_q;

    wire [15:0] mag       = dcms_abs(sample.bz);
    wire [15:0] threshold = out_q ? OPERATE_THRESHOLD : RELEASE_THRESHOLD;
    wire        field_on  = out_q ? (mag >= threshold) : !(mag < threshold);
    wire        take      = (state_q == dcms_pkg::DCMS_MEASURE) && sample.valid;
    // A long wait for a sample must not push the next wake past a counter wrap
    wire        period_end = (cnt_q >= 32'(SAMPLE_PERIOD_CYC - 1));
    wire        settle_end = (cnt_q == 32'(SETTLE_CYC - 1));

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 32'h00000001;
        out_d   = out_q;
        case (state_q)
            dcms_pkg::DCMS_SETTLE: begin
                state_d = dcms_pkg::DCMS_MEASURE;
            end
            dcms_pkg::DCMS_MEASURE: begin
                if (take) begin
                    out_d   = !field_on;
                    state_d = dcms_pkg::DCMS_SLEEP;
                end else if (first_q && settle_end) begin
                    state_d = dcms_pkg::DCMS_SLEEP;
                end
            end
            dcms_pkg::DCMS_SLEEP: begin
                if (period_end) begin
                    state_d = dcms_pkg::DCMS_MEASURE;
                    cnt_d   = 32'h00000000;
                end
            end
            default: state_d = dcms_pkg::DCMS_SETTLE;
        endcase
        if (state_q == dcms_pkg::DCMS_MEASURE && state_d == dcms_pkg::DCMS_SLEEP && !first_q)
            cnt_d = cnt_q + 32'h00000001;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= dcms_pkg::DCMS_SETTLE;
            cnt_q   <= 32'h00000000;
            out_q   <= 1'b1;
            first_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            out_q   <= out_d;
            if (state_q == dcms_pkg::DCMS_SLEEP)
                first_q <= 1'b0;
        end
    end

    assign sample_req = (state_q == dcms_pkg::DCMS_MEASURE);
    assign awake      = (state_q != dcms_pkg::DCMS_SLEEP);
    assign switch_out = out_q;

    // ****************************************************************
    // Check helpers
    // ****************************************************************
    // Cycles since the last wake, used to time the sample period
    logic [31:0] gap_q;
    logic        gap_run_q;

    wire         wake_edge  = (state_q == dcms_pkg::DCMS_SLEEP) && period_end;
    wire         in_band    = (mag >= RELEASE_THRESHOLD) && (mag < OPERATE_THRESHOLD);
    wire         first_miss = first_q && (state_q == dcms_pkg::DCMS_MEASURE)
                              && !take && settle_end;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gap_q     <= 32'h00000000;
            gap_run_q <= 1'b0;
        end else if (wake_edge) begin
            gap_q     <= 32'h00000000;
            gap_run_q <= 1'b1;
        end else begin
            gap_q     <= gap_q + 32'h00000001;
        end
    end

    // ****************************************************************
    // Output checks
    // ****************************************************************
    a_sleep_holds_out: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_q == dcms_pkg::DCMS_SLEEP) && $past(state_q == dcms_pkg::DCMS_SLEEP)
        |-> $stable(switch_out))
        else $error("output moved while asleep");

    a_field_drives_low: assert property (
        @(posedge clk) disable iff (!reset_n)
        take && (dcms_abs(sample.bz) >= OPERATE_THRESHOLD)
        |=> !switch_out)
        else $error("strong field did not drive output low");

    a_weak_drives_high: assert property (
        @(posedge clk) disable iff (!reset_n)
        take && (dcms_abs(sample.bz) < RELEASE_THRESHOLD)
        |=> switch_out)
        else $error("weak field did not release output");

    a_hyst_band_holds: assert property (
        @(posedge clk) disable iff (!reset_n)
        take && (dcms_abs(sample.bz) >= RELEASE_THRESHOLD)
        && (dcms_abs(sample.bz) < OPERATE_THRESHOLD) |=> $stable(switch_out))
        else $error("output changed inside hysteresis band");

    a_polarity_same: assert property (
        @(posedge clk) disable iff (!reset_n)
        take && sample.bz[15] && (dcms_abs(sample.bz) >= OPERATE_THRESHOLD)
        |=> !switch_out)
        else $error("negative field not detected");

    a_only_measure: assert property (
        @(posedge clk) disable iff (!reset_n)
        !take
        |=> $stable(switch_out))
        else $error("output changed without sample");

    a_reset_high: assert property (
        @(posedge clk)
        !reset_n
        |=> switch_out && awake && !sample_req)
        else $error("reset did not park output high");

    // ****************************************************************
    // Sequencing checks
    // ****************************************************************
    a_sample_sleeps: assert property (
        @(posedge clk) disable iff (!reset_n)
        take
        |=> (state_q == dcms_pkg::DCMS_SLEEP))
        else $error("no sleep after sample");

    a_req_drops: assert property (
        @(posedge clk) disable iff (!reset_n)
        take
        |=> !sample_req && !awake)
        else $error("request stayed up after sample");

    a_settle_start: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(reset_n)
        |-> ##1 sample_req)
        else $error("no first sample request");

    a_first_timeout: assert property (
        @(posedge clk) disable iff (!reset_n)
        first_miss
        |=> (state_q == dcms_pkg::DCMS_SLEEP) && switch_out)
        else $error("first wake did not give up in time");

    a_period_wake: assert property (
        @(posedge clk) disable iff (!reset_n)
        wake_edge && gap_run_q && (gap_q < 32'(SAMPLE_PERIOD_CYC))
        |-> (gap_q == 32'(SAMPLE_PERIOD_CYC - 1)))
        else $error("wake came before the sample period");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    c_assert_low: cover property (
        @(posedge clk) disable iff (!reset_n) $fell(switch_out));

    c_release_high: cover property (
        @(posedge clk) disable iff (!reset_n) $rose(switch_out));

    c_wake: cover property (
        @(posedge clk) disable iff (!reset_n) $rose(sample_req));

    c_first_timeout: cover property (
        @(posedge clk) disable iff (!reset_n) first_miss);

    c_band_hold_low: cover property (
        @(posedge clk) disable iff (!reset_n) take && in_band && !switch_out);

endmodule

//--- test/dcms_field_model.sv
`timescale 1ns/1ps
// Field front end: answers a request after lag cycles, garbage otherwise
module dcms_field_model (
    input  wire logic             clk,
    input  wire logic             sample_req,
    input  wire logic [15:0]      field,
    input  wire logic [1:0]       lag,
    input  wire logic             mute,
    output dcms_pkg::dcms_sample_s sample
);
    logic [1:0] wait_q = 2'h0;
    // Mute withholds every answer, to starve the first wake
    wire logic  valid_w = sample_req && !mute && (wait_q >= lag);

    always_ff @(posedge clk) begin
        if (!sample_req) begin
            wait_q <= 2'h0;
        end else if (wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end
    end

    // Inverted field while not valid, so stale data never looks right
    assign sample = {valid_w, valid_w ? field : ~field};
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int PER = 20;
    localparam int SET = 8;
    logic                   mute = 1'b0;
    logic                   clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic [15:0]            field = 16'h0000;
    logic [1:0]             lag = 2'h2;
    dcms_pkg::dcms_sample_s sample;
    logic                   sample_req;
    logic                   switch_out;
    logic                   awake;
    int                     num_errors = 0;
    int                     total_checks = 0;

    always #2.5 clk = ~clk;

    dcms_field_model i_model (.clk(clk), .sample_req(sample_req), .field(field), .lag(lag),
                              .mute(mute), .sample(sample));
    dcms_switch #(.SAMPLE_PERIOD_CYC(PER), .SETTLE_CYC(SET)) i_dut (.clk(clk),
        .reset_n(reset_n), .sample(sample), .sample_req(sample_req),
        .switch_out(switch_out), .awake(awake));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_count(input string name, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            num_errors++;
            $display("unexpected %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Waits for one taken sample, output must hold until then
    task automatic wake(input logic [15:0] f, input logic exp, input int limit);
        int   n;
        logic held;
        logic stable;
        field = f;
        n = 0;
        held = switch_out;
        stable = 1'b1;
        while (!(sample_req === 1'b1 && sample.valid === 1'b1) && n < limit) begin
            @(posedge clk);
            #1;
            n++;
            stable = stable & (switch_out === held);
        end
        check_bit("sample taken", 1'b1, n < limit);
        check_bit("held in sleep", 1'b1, stable);
        @(posedge clk);
        #1;
        check_bit("switch_out", exp, switch_out);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_power_up;
        wake(16'h0000, 1'b1, 8);
    endtask

    task automatic t_hysteresis;
        lag = 2'h0;
        wake(16'h001D, 1'b1, PER + 4);
        wake(16'h001E, 1'b0, PER + 4);
        wake(16'h001E, 1'b0, PER + 4);
        wake(16'h0016, 1'b0, PER + 4);
        wake(16'h0015, 1'b1, PER + 4);
    endtask

    task automatic t_polarity;
        lag = 2'h2;
        wake(16'hFFE3, 1'b1, PER + 6);
        wake(16'hFFE2, 1'b0, PER + 6);
        wake(16'hFFEA, 1'b0, PER + 6);
        wake(16'hFFEB, 1'b1, PER + 6);
    endtask

    // Wake to wake spacing is one sample period
    task automatic t_period;
        int n;
        lag = 2'h0;
        wake(16'h0000, 1'b1, PER + 4);
        n = 0;
        check_bit("awake", 1'b0, awake);
        check_bit("sample_req", 1'b0, sample_req);
        while (sample_req !== 1'b1 && n < 2 * PER) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_count("sleep cycles", PER - 1, n);
        check_bit("awake", 1'b1, awake);
    endtask

    // Reset in mid-run, then a first wake that never gets a sample
    task automatic t_reset_mid;
        int n;
        wake(16'h0040, 1'b0, PER + 6);
        mute = 1'b1;
        reset_n = 1'b0;
        @(posedge clk);
        #1;
        check_bit("switch_out in reset", 1'b1, switch_out);
        check_bit("awake in reset", 1'b1, awake);
        @(posedge clk);
        #1;
        reset_n = 1'b1;
        @(posedge clk);
        #1;
        check_bit("sample_req", 1'b1, sample_req);
        n = 0;
        while (sample_req === 1'b1 && n < 2 * SET) begin
            @(posedge clk);
            #1;
            n++;
        end
        // Counter starts at one on entering the first wake
        check_count("settle cycles", SET - 1, n);
        check_bit("awake", 1'b0, awake);
        check_bit("switch_out", 1'b1, switch_out);
        mute = 1'b0;
        wake(16'h0040, 1'b0, PER + 6);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_power_up();
        t_hysteresis();
        t_polarity();
        t_period();
        t_reset_mid();
        end_sim();
    end

    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
endmodule
